// *** logic/ibsf_pkg.sv ***
// Constants and types for the indexed bit-set and byte-fill executor
package ibsf_pkg;
	// Data path widths
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int INSN_W = 16;
	localparam int MEM_DEPTH = 4096;
	// Opcode fields
	localparam logic [3:0] OPC_BIT_SET = 4'h8;
	localparam logic [6:0] OPC_FILL = 7'h34;
	localparam int OPC_BIT_SET_MSB = 15;
	localparam int OPC_FILL_MSB = 15;
	localparam int FLD_BIT_LSB = 9;
	localparam int FLD_ACCESS = 8;
	// Operand limits and constants
	localparam logic [7:0] INDEX_MAX = 8'h5F;
	localparam logic [7:0] FILL_VALUE = 8'hFF;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
	localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
	// Reset values
	localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	localparam logic [INSN_W-1:0] INSN_RST = 16'h0000;
	// Operation kinds
	typedef enum logic [1:0]
	{
		IBSF_OP_NONE = 2'b00,
		IBSF_OP_BIT_SET = 2'b01,
		IBSF_OP_FILL = 2'b10
	} ibsf_op_t;
	// Instruction phases, Gray coded from idle to Q4, two bits change on the return to idle
	typedef enum logic [2:0]
	{
		IBSF_IDLE = 3'b000,
		IBSF_Q1 = 3'b001,
		IBSF_Q2 = 3'b011,
		IBSF_Q3 = 3'b010,
		IBSF_Q4 = 3'b110
	} ibsf_state_t;
endpackage

// *** logic/ibsf_mem_if.sv ***
// Carrier between the executor and its data memory
`timescale 1ns/10ps
interface ibsf_mem_if;
	import ibsf_pkg::*;
	logic              re;
	logic              we;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	modport core (output re, output we, output addr, output wdata, input rdata);
	modport mem (input re, input we, input addr, input wdata, output rdata);
endinterface

// *** logic/ibsf_mem.sv ***
// Byte-wide data memory with registered read data
`timescale 1ns/10ps
module ibsf_mem
(
	// Clock
	input  wire logic mclk_i,
	// Access port
	ibsf_mem_if.mem   port
);
	import ibsf_pkg::*;

	logic [DATA_W-1:0] store [MEM_DEPTH];

	// Write and registered read
	always_ff @(posedge mclk_i)
	begin
		if (port.we)
			store[port.addr] <= port.wdata;
		if (port.re)
			port.rdata <= store[port.addr];
	end
endmodule

// *** logic/ibsf_core.sv ***
// Decode and execute of the indexed bit-set and byte-fill instructions
// Operation
// - Bit set touches only bit b at pointer+k
// - Offset 0..95, bit 0..7, flags untouched
// - Byte fill writes FFh at pointer+k, flags untouched
// - Config bit clear gives standard decoding only
// - Indexed form only with config bit set
// - Indexed only for operand 5Fh or below
// - Access bit treated as zero when indexed
`timescale 1ns/10ps
module ibsf_core
(
	// Clock and reset
	input  wire logic                  mclk_i,
	input  wire logic                  rstn_i,
	// Configuration strap
	input  wire logic                  extended_set_enable_cfg_i,
	// Instruction issue
	input  wire logic                  insn_valid_i,
	input  wire logic [ibsf_pkg::INSN_W-1:0] insn_i,
	input  wire logic [ibsf_pkg::ADDR_W-1:0] frame_pointer_i,
	input  wire logic [3:0]            bank_select_i,
	output      logic                  ready_o,
	output      logic                  done_o,
	output      logic                  indexed_o,
	output      logic                  status_we_o,
	output      logic [ibsf_pkg::ADDR_W-1:0] target_addr_o,
	output      logic [ibsf_pkg::DATA_W-1:0] write_data_o,
	// Memory inspection port, served while idle
	input  wire logic                  dbg_en_i,
	input  wire logic                  dbg_we_i,
	input  wire logic [ibsf_pkg::ADDR_W-1:0] dbg_addr_i,
	input  wire logic [ibsf_pkg::DATA_W-1:0] dbg_wdata_i,
	output      logic [ibsf_pkg::DATA_W-1:0] dbg_rdata_o
);
	import ibsf_pkg::*;

	ibsf_mem_if mem_bus ();

	ibsf_state_t       state;
	ibsf_state_t       next_state;
	logic [INSN_W-1:0] insn;
	logic [ADDR_W-1:0] fp;
	logic [3:0]        bank;
	ibsf_op_t          op;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] mask;
	logic [DATA_W-1:0] wdata;
	logic [2:0]        cfg_sync;
	logic [2:0]        sync_fill;
	logic              cfg_settle;
	logic              cfg_taken;
	logic              ext_en;
	logic              dbg_pend;
	logic              take;

	// Operation kind of an instruction word
	function automatic ibsf_op_t op_of(input logic [INSN_W-1:0] w);
		ibsf_op_t k;
		k = IBSF_OP_NONE;
		if (w[OPC_BIT_SET_MSB -: 4] == OPC_BIT_SET)
			k = IBSF_OP_BIT_SET;
		else if (w[OPC_FILL_MSB -: 7] == OPC_FILL)
			k = IBSF_OP_FILL;
		return k;
	endfunction

	assign take = (state == IBSF_IDLE) && cfg_taken && insn_valid_i;

	// Strap may be taken only once the third stage holds a real sample,
	// since the reset zeros in stages two and three agree trivially
	assign cfg_settle = !cfg_taken && sync_fill[2] && (cfg_sync[1] == cfg_sync[2]);

	// Strap synchroniser, three stages, with its fill marker
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			cfg_sync <= 3'b000;
			sync_fill <= 3'b000;
		end
		else
		begin
			cfg_sync <= {cfg_sync[1:0], extended_set_enable_cfg_i};
			sync_fill <= {sync_fill[1:0], 1'b1};
		end
	end

	// Strap captured once, after stages two and three agree
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			cfg_taken <= 1'b0;
			ext_en <= 1'b0;
		end
		else if (cfg_settle)
		begin
			cfg_taken <= 1'b1;
			ext_en <= cfg_sync[2];
		end
	end

	// Phase sequencer
	always_comb
	begin
		next_state = state;
		case (state)
			IBSF_IDLE:
				if (take)
					next_state = IBSF_Q1;
			IBSF_Q1:
				next_state = IBSF_Q2;
			IBSF_Q2:
				next_state = IBSF_Q3;
			IBSF_Q3:
				next_state = IBSF_Q4;
			IBSF_Q4:
				next_state = IBSF_IDLE;
			default:
				next_state = IBSF_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			state <= IBSF_IDLE;
		else
			state <= next_state;
	end

	// Instruction and pointer latch at issue
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			insn <= INSN_RST;
			fp <= ADDR_RST;
			bank <= ACCESS_LOW_BANK;
		end
		else if (take)
		begin
			insn <= insn_i;
			fp <= frame_pointer_i;
			bank <= bank_select_i;
		end
	end

	// Q1 decode: kind, target address, bit mask
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			op <= IBSF_OP_NONE;
			addr <= ADDR_RST;
			mask <= DATA_RST;
			indexed_o <= 1'b0;
		end
		else if (state == IBSF_Q1)
		begin
			op <= op_of(insn);
			mask <= DATA_W'(1) << insn[FLD_BIT_LSB +: 3];
			if (ext_en && !insn[FLD_ACCESS] && (insn[7:0] <= INDEX_MAX))
			begin
				addr <= fp + {4'h0, insn[7:0]};
				indexed_o <= 1'b1;
			end
			else if (insn[FLD_ACCESS])
			begin
				addr <= {bank, insn[7:0]};
				indexed_o <= 1'b0;
			end
			else
			begin
				addr <= {(insn[7:0] <= INDEX_MAX) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, insn[7:0]};
				indexed_o <= 1'b0;
			end
		end
	end

	// Q3 modify: set one bit or fill with ones
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			wdata <= DATA_RST;
		else if (state == IBSF_Q3)
		begin
			if (op == IBSF_OP_FILL)
				wdata <= FILL_VALUE;
			else
				wdata <= mem_bus.rdata | mask;
		end
	end

	// Memory port: Q2 read, Q4 write, inspection while idle
	always_comb
	begin
		mem_bus.re = 1'b0;
		mem_bus.we = 1'b0;
		mem_bus.addr = addr;
		mem_bus.wdata = wdata;
		if (state == IBSF_Q2)
			mem_bus.re = 1'b1;
		else if (state == IBSF_Q4)
			mem_bus.we = (op != IBSF_OP_NONE);
		else if ((state == IBSF_IDLE) && !take && dbg_en_i)
		begin
			mem_bus.addr = dbg_addr_i;
			mem_bus.wdata = dbg_wdata_i;
			mem_bus.we = dbg_we_i;
			mem_bus.re = !dbg_we_i;
		end
	end

	ibsf_mem u_mem
	(
		.mclk_i (mclk_i),
		.port   (mem_bus.mem)
	);

	// Inspection read data returned two cycles after the request
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			dbg_pend <= 1'b0;
			dbg_rdata_o <= DATA_RST;
		end
		else
		begin
			dbg_pend <= (state == IBSF_IDLE) && !take && dbg_en_i && !dbg_we_i;
			if (dbg_pend)
				dbg_rdata_o <= mem_bus.rdata;
		end
	end

	// Completion and status outputs
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			ready_o <= 1'b0;
			done_o <= 1'b0;
			status_we_o <= 1'b0;
			target_addr_o <= ADDR_RST;
			write_data_o <= DATA_RST;
		end
		else
		begin
			ready_o <= (next_state == IBSF_IDLE) && (cfg_taken || cfg_settle);
			done_o <= (state == IBSF_Q4);
			status_we_o <= 1'b0;
			if (state == IBSF_Q4)
			begin
				target_addr_o <= addr;
				write_data_o <= (op == IBSF_OP_NONE) ? DATA_RST : wdata;
			end
		end
	end
endmodule

// *** sim/ibsf_fp_reg.sv ***
// Frame pointer register model standing beside the executor
`timescale 1ns/10ps
module ibsf_fp_reg
(
	// Clock
	input  wire logic        mclk_i,
	// Load port
	input  wire logic        ld_i,
	input  wire logic [11:0] val_i,
	// Pointer value
	output      logic [11:0] fp_o
);
	// Holds until reloaded, like a pointer register
	always_ff @(posedge mclk_i)
		if (ld_i)
			fp_o <= val_i;
endmodule

// *** sim/ibsf_chk.sv ***
// Port assertions for the indexed bit-set and byte-fill executor
`timescale 1ns/10ps
module ibsf_chk
(
	// Clock, reset, strap
	input wire logic        mclk_i,
	input wire logic        rstn_i,
	input wire logic        extended_set_enable_cfg_i,
	// Issue side
	input wire logic        insn_valid_i,
	input wire logic [15:0] insn_i,
	input wire logic [11:0] frame_pointer_i,
	input wire logic [3:0]  bank_select_i,
	// Results
	input wire logic        ready_o,
	input wire logic        done_o,
	input wire logic        indexed_o,
	input wire logic        status_we_o,
	input wire logic [11:0] target_addr_o,
	input wire logic [7:0]  write_data_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	// Issue taken, and address forms
	wire       tk = insn_valid_i && ready_o;
	wire       ix = extended_set_enable_cfg_i && !insn_i[8] && insn_i[7:0] <= 8'h5F;
	wire [11:0] ia = frame_pointer_i + {4'h0, insn_i[7:0]};
	wire [11:0] sa = {{4{insn_i[7:0] > 8'h5F}}, insn_i[7:0]};
	wire [11:0] ba = {bank_select_i, insn_i[7:0]};
	wire [2:0]  bb = insn_i[11:9];
	sequence run_s; !ready_o [*4] ##1 (ready_o && done_o); endsequence
	chk_one_cycle: assert property (tk |=> run_s) else $error("phases wrong");
	chk_done_pulse: assert property (done_o |=> !done_o) else $error("done held");
	chk_flags_kept: assert property (!status_we_o) else $error("status write");
	chk_fill_ones: assert property (tk && insn_i[15:9] == 7'h34 |-> ##5 write_data_o == 8'hFF)
		else $error("fill not ones");
	chk_bit_set: assert property (tk && insn_i[15:12] == 4'h8 |-> ##5 write_data_o[$past(bb, 5)])
		else $error("bit not set");
	chk_idx_addr: assert property (tk && ix |-> ##5 indexed_o && target_addr_o == $past(ia, 5))
		else $error("indexed address");
	chk_std_addr: assert property (tk && !ix && !insn_i[8] |-> ##5 !indexed_o && target_addr_o == $past(sa, 5))
		else $error("standard address");
	chk_bank_addr: assert property (tk && insn_i[8] |-> ##5 !indexed_o && target_addr_o == $past(ba, 5))
		else $error("banked address");
endmodule
bind ibsf_core ibsf_chk u_chk (.mclk_i(mclk_i), .rstn_i(rstn_i), .extended_set_enable_cfg_i(extended_set_enable_cfg_i),
	.insn_valid_i(insn_valid_i), .insn_i(insn_i), .frame_pointer_i(frame_pointer_i), .bank_select_i(bank_select_i),
	.ready_o(ready_o), .done_o(done_o), .indexed_o(indexed_o), .status_we_o(status_we_o),
	.target_addr_o(target_addr_o), .write_data_o(write_data_o));

// *** sim/testbench.sv ***
// Self-checking bench for the indexed bit-set and byte-fill executor
`timescale 1ns/10ps
module testbench;
	logic        mclk_i = 0, rstn_i = 0, cfg = 1, iv = 0, de = 0, ld = 0, dw = 1;
	logic        rdy, done, idx;
	logic [15:0] insn = 0;
	logic [11:0] fpv = 0, fp, da = 0, ta;
	logic [7:0]  dd = 0, wd, dr;
	logic [3:0]  bk = 0;
	logic [31:0] s = 32'hb6fc;
	logic [20:0] q[$];
	logic [7:0]  qm[$];
	logic [1:0]  rp = 0;
	int          failures = 0, n_compared = 0;
	always #5 mclk_i = ~mclk_i;
	ibsf_fp_reg FP (.mclk_i(mclk_i), .ld_i(ld), .val_i(fpv), .fp_o(fp));
	ibsf_core DUT (.mclk_i(mclk_i), .rstn_i(rstn_i), .extended_set_enable_cfg_i(cfg), .insn_valid_i(iv),
		.insn_i(insn), .frame_pointer_i(fp), .bank_select_i(bk), .ready_o(rdy), .done_o(done), .indexed_o(idx),
		.status_we_o(), .target_addr_o(ta), .write_data_o(wd), .dbg_en_i(de), .dbg_we_i(dw), .dbg_addr_i(da),
		.dbg_wdata_i(dd), .dbg_rdata_o(dr));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	task automatic conclude();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic cmp(input logic [20:0] got, input logic [20:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic cmp_mem(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: memory %h want %h", $time, got, exp);
		end
	endtask
	// Bounded wait for the idle level, from the next falling edge so that
	// a ready seen before the taking edge's update is never trusted
	task automatic wait_rdy();
		int i;
		@(negedge mclk_i);
		for (i = 0; i < 20 && rdy !== 1'b1; i++)
			@(negedge mclk_i);
		if (rdy !== 1'b1)
		begin
			failures++;
			conclude();
		end
	endtask
	// Preload target and pointer, then issue one word
	task automatic op(input logic [15:0] w, input logic [7:0] pre, input logic [20:0] e);
		wait_rdy();
		@(posedge mclk_i);
		de <= 1;
		da <= e[19:8];
		dd <= pre;
		ld <= 1;
		@(posedge mclk_i);
		de <= 0;
		ld <= 0;
		insn <= w;
		iv <= 1;
		q.push_back(e);
		@(posedge mclk_i);
		iv <= 0;
	endtask
	// Read one byte back through the inspection port
	task automatic peek(input logic [11:0] a, input logic [7:0] exp);
		wait_rdy();
		@(posedge mclk_i);
		de <= 1;
		dw <= 0;
		da <= a;
		qm.push_back(exp);
		@(posedge mclk_i);
		de <= 0;
		dw <= 1;
		repeat (2) @(posedge mclk_i);
	endtask
	// Result monitor against the oldest note
	always @(negedge mclk_i)
		if (done === 1'b1)
			cmp({idx, ta, wd}, q.pop_front());
	// Inspection reads answer two edges after their request
	always @(posedge mclk_i)
		rp <= {rp[0], de && !dw};
	always @(negedge mclk_i)
		if (rp[1])
			cmp_mem(dr, qm.pop_front());
	initial
	begin
		logic [7:0]  k;
		logic [15:0] w;
		logic [20:0] e;
		logic [7:0]  m;
		int          r, i;
		for (r = 0; r < 2; r++)
		begin
			@(posedge mclk_i);
			rstn_i <= 0;
			cfg <= (r == 0);
			repeat (5) @(posedge mclk_i);
			rstn_i <= 1;
			for (i = 0; i < 24; i++)
			begin
				s = xs(s);
				k = (i % 4 == 0) ? 8'h5F : (i % 4 == 1) ? 8'h60 : s[7:0];
				fpv <= s[19:8];
				bk <= s[23:20];
				w = i[0] ? {7'h34, s[24], k} : {4'h8, s[27:25], s[24], k};
				// Every eighth word is neither kind and must write nothing
				if (i % 8 == 7)
					w[15:12] = 4'h2;
				e[20] = !s[24] && r == 0 && k <= 8'h5F;
				e[19:8] = s[24] ? {s[23:20], k} : e[20] ? s[19:8] + k : {{4{k > 8'h5F}}, k};
				s = xs(s);
				e[7:0] = (i % 8 == 7) ? 8'h00 : i[0] ? 8'hFF : s[7:0] | (8'h01 << w[11:9]);
				m = (i % 8 == 7) ? s[7:0] : e[7:0];
				op(w, s[7:0], e);
				peek(e[19:8], m);
			end
			wait_rdy();
			$display("strap %0d run done", 1 - r);
		end
		conclude();
	end
endmodule
